// ### include/pmf_pkg.sv
// Functional notes
// - keep positive, negative, zero flags; update on each evoked transfer
// - page, mux, halt commands leave bus zero, so zero flag sets
// - reexamine_accum/reexamine_argument re-test registers for flags
// - select_test_mux_first/second pick the mux for conditional jumps
// - channel 0 of both multiplexers reads true; unconditional jump taken
// - multiplexer choice holds until the opposite select command executes
// - after power-on the first multiplexer is selected
// - mux selection exists only with the second-multiplexer option
// - paging applies only when more than 512 control words are fitted
// - after power-on program page 0 is selected
// - 1024-word control memory splits into two 512-word pages
// - direct addressing reaches only the current page
// - page low/high commands drive one page select flip-flop
// - after a page command fetch continues at in-page address plus one
// - program counter wraps within the page, never crossing
// - jumps, calls and returns stay in the current page
// - false test only advances pc; true test fetches low target byte
// - opcode low bit becomes top bit of the in-page jump target
// - calls push 9-bit return address on a 16-deep stack; returns pop
package pmf_pkg;

    localparam int PMF_PC_W = 9;
    localparam int PMF_ADDR_W = 10;
    localparam int PMF_WORD_W = 16;
    localparam int PMF_SIGN_BIT = 15;
    localparam int PMF_STACK_DEPTH = 16;
    localparam int PMF_SP_W = 4;
    localparam int PMF_CHANS = 30;
    localparam int PMF_CHAN_W = 5;
    localparam int PMF_CHAN_LSB = 1;
    localparam int PMF_HALF_BIT = 0;
    localparam int PMF_WORDS_FITTED = 1024;
    localparam int PMF_PAGE_WORDS = 512;

    localparam logic [PMF_PC_W-1:0] PMF_PC_STEP = 9'h001;
    localparam logic [PMF_PC_W-1:0] PMF_OPERAND_SKIP = 9'h002;
    localparam logic [PMF_PC_W-1:0] PMF_PC_RESET = 9'h000;
    localparam logic [PMF_SP_W-1:0] PMF_SP_STEP = 4'h1;
    localparam logic [PMF_CHAN_W-1:0] PMF_CHAN_ALWAYS = 5'h00;

    // opcode map: transfers 000-277 octal, jumps 300-373, calls, return
    localparam logic [7:0] PMF_OP_LAST_EVOKE = 8'hBF;
    localparam logic [7:0] PMF_OP_PAGE_LOW = 8'hB0;
    localparam logic [7:0] PMF_OP_PAGE_HIGH = 8'hB1;
    localparam logic [7:0] PMF_OP_MUX_FIRST = 8'hB2;
    localparam logic [7:0] PMF_OP_MUX_SECOND = 8'hB3;
    localparam logic [7:0] PMF_OP_REEXAM_ACCUM = 8'hB4;
    localparam logic [7:0] PMF_OP_REEXAM_ARG = 8'hB5;
    localparam logic [7:0] PMF_OP_HALT = 8'hB6;
    localparam logic [7:0] PMF_OP_JUMP_FIRST = 8'hC0;
    localparam logic [7:0] PMF_OP_JUMP_LAST = 8'hFB;
    localparam logic [7:0] PMF_OP_CALL_LOW = 8'hFC;
    localparam logic [7:0] PMF_OP_CALL_HIGH = 8'hFD;
    localparam logic [7:0] PMF_OP_RETURN = 8'hFF;

    typedef enum logic [2:0] {
        PMF_S_FETCH = 3'b000,
        PMF_S_DECODE = 3'b001,
        PMF_S_EVOKE = 3'b010,
        PMF_S_TARGET = 3'b011,
        PMF_S_POP = 3'b100,
        PMF_S_HALT = 3'b101
    } pmf_state_t;

    typedef struct packed {
        logic positive;
        logic negative;
        logic zero;
    } pmf_flags_t;

    typedef struct packed {
        logic req;
        logic [PMF_ADDR_W-1:0] addr;
    } pmf_mem_req_t;

    localparam pmf_flags_t PMF_FLAGS_RESET = 3'h0;
    localparam pmf_flags_t PMF_FLAGS_ZERO = 3'h1;

endpackage

// ### rtl/pmf_stack_ram.sv
`timescale 1ns/1ps
// return-address store, read data registered
module pmf_stack_ram
    import pmf_pkg::*;
#(
    parameter int DEPTH = PMF_STACK_DEPTH,
    parameter int WIDTH = PMF_PC_W,
    parameter int AW = PMF_SP_W
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] rd;
    } pmf_ram_t;

    pmf_ram_t q;
    pmf_ram_t next_q;

    // read is always live; caller waits one edge for data
    always_comb begin
        next_q = q;
        if (wr_en) begin
            next_q.mem[wr_addr] = wr_data;
        end
        next_q.rd = q.mem[rd_addr];
        if (!rst_b) begin
            next_q.rd = '0;
        end
    end

    always_ff @(posedge mclk) begin
        q <= next_q;
    end

    assign rd_data = q.rd;

endmodule

// ### rtl/pmf_test_mux.sv
`timescale 1ns/1ps
// two boolean test multiplexers with pin synchronisers
module pmf_test_mux
    import pmf_pkg::*;
#(
    parameter int CHANS = PMF_CHANS,
    parameter bit HAS_SECOND = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [CHANS-1:0] test_first,
    input wire logic [CHANS-1:0] test_second,
    input wire logic use_second,
    input wire logic [PMF_CHAN_W-1:0] chan,
    output logic test_true
);

    typedef struct packed {
        logic [CHANS-1:0] meta_first;
        logic [CHANS-1:0] sync_first;
        logic [CHANS-1:0] meta_second;
        logic [CHANS-1:0] sync_second;
    } pmf_mux_t;

    pmf_mux_t q;
    pmf_mux_t next_q;

    // two stages per line; only the second stage is looked at
    always_comb begin
        next_q.meta_first = test_first;
        next_q.sync_first = q.meta_first;
        next_q.meta_second = test_second;
        next_q.sync_second = q.meta_second;
        if (!rst_b) begin
            next_q = '0;
        end
    end

    always_ff @(posedge mclk) begin
        q <= next_q;
    end

    always_comb begin
        if (chan == PMF_CHAN_ALWAYS) begin
            test_true = 1'b1;
        end else if (HAS_SECOND && use_second) begin
            test_true = q.sync_second[chan];
        end else begin
            test_true = q.sync_first[chan];
        end
    end

endmodule

// ### rtl/pmf_sequencer.sv
`timescale 1ns/1ps
// program sequencer with page, mux select and result flags
module pmf_sequencer
    import pmf_pkg::*;
#(
    parameter bit HAS_MUX_SECOND = 1'b1,
    parameter int WORDS_FITTED = PMF_WORDS_FITTED
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data,
    output pmf_mem_req_t mem,
    output logic evoke_valid,
    output logic [7:0] evoke_code,
    input wire logic xfer_done,
    input wire logic [PMF_WORD_W-1:0] bus_data,
    input wire logic [PMF_WORD_W-1:0] accum_data,
    input wire logic [PMF_WORD_W-1:0] arg_data,
    input wire logic [PMF_CHANS-1:0] test_first,
    input wire logic [PMF_CHANS-1:0] test_second,
    output pmf_flags_t flags,
    output logic page_sel,
    output logic mux_sel,
    output logic halted
);

    // ------------------------------------------------------------
    // build options
    // ------------------------------------------------------------

    localparam bit PAGED = (WORDS_FITTED > PMF_PAGE_WORDS);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------

    typedef struct packed {
        pmf_state_t state;
        logic [PMF_PC_W-1:0] pc;
        logic [7:0] instr;
        logic page;
        logic mux;
        logic hi;
        logic [PMF_SP_W-1:0] sp;
        pmf_flags_t flags;
        pmf_mem_req_t mem;
        logic evoke;
        logic halted;
    } pmf_seq_t;

    pmf_seq_t q;
    pmf_seq_t next_q;

    logic test_true;
    logic [PMF_CHAN_W-1:0] chan;
    logic push;
    logic [PMF_PC_W-1:0] ret_addr;
    logic [PMF_SP_W-1:0] pop_addr;
    logic [PMF_PC_W-1:0] pop_data;
    logic [7:0] op;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------

    // sign and zero test of a bus word
    function automatic pmf_flags_t pmf_test_word(
        input logic [PMF_WORD_W-1:0] w
    );
        pmf_flags_t f;
        f.zero = (w == '0);
        f.negative = w[PMF_SIGN_BIT];
        f.positive = !w[PMF_SIGN_BIT] && (w != '0);
        return f;
    endfunction

    function automatic logic [PMF_ADDR_W-1:0] pmf_ctrl_addr(
        input logic page,
        input logic [PMF_PC_W-1:0] pc
    );
        return {page, pc};
    endfunction

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------

    assign op = q.instr;
    assign chan = op[PMF_CHAN_LSB +: PMF_CHAN_W];

    pmf_test_mux #(
        .CHANS(PMF_CHANS),
        .HAS_SECOND(HAS_MUX_SECOND)
    ) u_mux (
        .mclk(mclk),
        .rst_b(rst_b),
        .test_first(test_first),
        .test_second(test_second),
        .use_second(q.mux),
        .chan(chan),
        .test_true(test_true)
    );

    // return address skips the target byte
    assign push = (q.state == PMF_S_DECODE)
        && ((op == PMF_OP_CALL_LOW) || (op == PMF_OP_CALL_HIGH));
    assign ret_addr = q.pc + PMF_OPERAND_SKIP;
    // read runs ahead so data is ready one edge after decode
    assign pop_addr = q.sp - PMF_SP_STEP;

    pmf_stack_ram #(
        .DEPTH(PMF_STACK_DEPTH),
        .WIDTH(PMF_PC_W),
        .AW(PMF_SP_W)
    ) u_stack (
        .mclk(mclk),
        .rst_b(rst_b),
        .wr_en(push),
        .wr_addr(q.sp),
        .wr_data(ret_addr),
        .rd_addr(pop_addr),
        .rd_data(pop_data)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------

    always_comb begin
        next_q = q;
        case (q.state)
            // instruction fetch; request held until answered
            PMF_S_FETCH: begin
                if (q.mem.req && mem_ack) begin
                    next_q.mem.req = 1'b0;
                    next_q.instr = mem_data;
                    next_q.state = PMF_S_DECODE;
                end else begin
                    next_q.mem.req = 1'b1;
                    next_q.mem.addr = pmf_ctrl_addr(q.page, q.pc);
                end
            end

            PMF_S_DECODE: begin
                next_q.pc = q.pc + PMF_PC_STEP;
                next_q.state = PMF_S_FETCH;
                if (op == PMF_OP_PAGE_LOW || op == PMF_OP_PAGE_HIGH) begin
                    if (PAGED) begin
                        next_q.page = (op == PMF_OP_PAGE_HIGH);
                    end
                    next_q.flags = PMF_FLAGS_ZERO;
                    next_q.state = PMF_S_FETCH;
                end else if (op == PMF_OP_MUX_FIRST
                    || op == PMF_OP_MUX_SECOND) begin
                    if (HAS_MUX_SECOND) begin
                        next_q.mux = (op == PMF_OP_MUX_SECOND);
                    end
                    next_q.flags = PMF_FLAGS_ZERO;
                end else if (op == PMF_OP_HALT) begin
                    next_q.flags = PMF_FLAGS_ZERO;
                    next_q.halted = 1'b1;
                    next_q.pc = q.pc;
                    next_q.state = PMF_S_HALT;
                end else if (op == PMF_OP_REEXAM_ACCUM) begin
                    next_q.flags = pmf_test_word(accum_data);
                end else if (op == PMF_OP_REEXAM_ARG) begin
                    next_q.flags = pmf_test_word(arg_data);
                end else if (op <= PMF_OP_LAST_EVOKE) begin
                    // data transfer: hand code to the decoders
                    next_q.pc = q.pc;
                    next_q.evoke = 1'b1;
                    next_q.state = PMF_S_EVOKE;
                end else if (op >= PMF_OP_JUMP_FIRST
                    && op <= PMF_OP_JUMP_LAST) begin
                    if (test_true) begin
                        next_q.hi = op[PMF_HALF_BIT];
                        next_q.state = PMF_S_TARGET;
                    end else begin
                        next_q.pc = q.pc + PMF_OPERAND_SKIP;
                    end
                end else if (op == PMF_OP_CALL_LOW
                    || op == PMF_OP_CALL_HIGH) begin
                    next_q.sp = q.sp + PMF_SP_STEP;
                    next_q.hi = op[PMF_HALF_BIT];
                    next_q.state = PMF_S_TARGET;
                end else if (op == PMF_OP_RETURN) begin
                    next_q.sp = pop_addr;
                    next_q.pc = q.pc;
                    next_q.state = PMF_S_POP;
                end
                // unassigned opcodes fall through as a step
            end

            // wait for the interlocked transfer to finish
            PMF_S_EVOKE: begin
                if (xfer_done) begin
                    next_q.evoke = 1'b0;
                    next_q.flags = pmf_test_word(bus_data);
                    next_q.pc = q.pc + PMF_PC_STEP;
                    next_q.state = PMF_S_FETCH;
                end
            end

            // low eight bits of the in-page target
            PMF_S_TARGET: begin
                if (q.mem.req && mem_ack) begin
                    next_q.mem.req = 1'b0;
                    next_q.pc = {q.hi, mem_data};
                    next_q.state = PMF_S_FETCH;
                end else begin
                    next_q.mem.req = 1'b1;
                    next_q.mem.addr = pmf_ctrl_addr(q.page, q.pc);
                end
            end

            PMF_S_POP: begin
                next_q.pc = pop_data;
                next_q.state = PMF_S_FETCH;
            end

            // stopped until reset
            PMF_S_HALT: begin
                next_q.state = PMF_S_HALT;
            end

            default: begin
                next_q.state = PMF_S_FETCH;
            end
        endcase

        if (!rst_b) begin
            next_q.state = PMF_S_FETCH;
            next_q.pc = PMF_PC_RESET;
            next_q.instr = '0;
            next_q.page = 1'b0;
            next_q.mux = 1'b0;
            next_q.hi = 1'b0;
            next_q.sp = '0;
            next_q.flags = PMF_FLAGS_RESET;
            next_q.mem = '0;
            next_q.evoke = 1'b0;
            next_q.halted = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------

    // mux and page hold between commands
    always_ff @(posedge mclk) begin
        q <= next_q;
    end

    // ------------------------------------------------------------
    // outputs, all straight from flops
    // ------------------------------------------------------------

    assign mem = q.mem;
    assign evoke_valid = q.evoke;
    assign evoke_code = q.instr;
    // flags visible to the test mux owner
    assign flags = q.flags;
    assign page_sel = q.page;
    assign mux_sel = q.mux;
    assign halted = q.halted;

endmodule

// ### test/pmf_far_side.sv
`timescale 1ns/1ps
// control memory and data bus partner, answering after a set wait
module pmf_far_side
    import pmf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [3:0] delay,
    input wire logic [PMF_WORD_W-1:0] word,
    input wire pmf_mem_req_t mem,
    input wire logic evoke_valid,
    output logic mem_ack,
    output logic [7:0] mem_data,
    output logic xfer_done,
    output logic [PMF_WORD_W-1:0] bus_data
);
    logic [7:0] rom [0:PMF_WORDS_FITTED-1];
    logic [3:0] mem_wait;
    logic [3:0] bus_wait;
    logic mem_go;
    logic bus_go;

    initial begin
        mem_data = 8'h5A;
        bus_data = 16'hA5C3;
    end

    assign mem_go = mem.req && !mem_ack && mem_wait == delay;
    assign bus_go = evoke_valid && !xfer_done && bus_wait == delay;

    // released lines toggle so stale data can never pass as an answer
    always @(posedge mclk) begin
        mem_data <= mem_go ? rom[mem.addr] : ~mem_data;
        bus_data <= bus_go ? word : ~bus_data;
        if (!rst_b) begin
            mem_ack <= 1'b0;
            xfer_done <= 1'b0;
            mem_wait <= 4'h0;
            bus_wait <= 4'h0;
        end else begin
            mem_ack <= mem_go;
            // bus word offered at transfer end
            xfer_done <= bus_go;
            mem_wait <= (mem.req && !mem_ack && !mem_go)
                ? mem_wait + 4'h1 : 4'h0;
            bus_wait <= (evoke_valid && !bus_go) ? bus_wait + 4'h1 : 4'h0;
        end
    end
endmodule

// ### test/pmf_sequencer_assertions.sv
`timescale 1ns/1ps
// port-level checks of the sequencer handshakes and state
module pmf_sequencer_assertions
    import pmf_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data,
    input wire pmf_mem_req_t mem,
    input wire logic evoke_valid,
    input wire logic [7:0] evoke_code,
    input wire logic xfer_done,
    input wire logic [PMF_WORD_W-1:0] bus_data,
    input wire pmf_flags_t flags,
    input wire logic page_sel,
    input wire logic mux_sel,
    input wire logic halted
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_req_holds: assert property (mem.req && !mem_ack |=>
        mem.req && $stable(mem.addr)) else $error("request moved");
    a_req_drops: assert property (mem.req && mem_ack |=> !mem.req)
        else $error("request kept after ack");
    a_addr_page: assert property (mem.req |->
        mem.addr[9] == page_sel) else $error("address page bit wrong");
    a_flags_bus: assert property (evoke_valid && xfer_done |=>
        flags.zero == ($past(bus_data) == 16'h0000) &&
        flags.negative == $past(bus_data[PMF_SIGN_BIT]) &&
        flags.positive == ($past(bus_data) != 16'h0000 &&
        !$past(bus_data[PMF_SIGN_BIT]))) else $error("flags not from bus");
    a_evoke_holds: assert property (evoke_valid && !xfer_done |=>
        evoke_valid && $stable(evoke_code)) else $error("evoke moved");
    a_evoke_ends: assert property (evoke_valid && xfer_done |=> !evoke_valid)
        else $error("evoke kept after done");
    a_reset_state: assert property (disable iff (1'b0)
        !rst_b |=> !mem.req && flags == 3'h0 && !page_sel && !mux_sel &&
        !halted) else $error("reset state wrong");
    a_first_fetch: assert property ($rose(rst_b) |=>
        mem.req && mem.addr == 10'h000) else $error("first fetch wrong");
    a_halt_zero: assert property ($rose(halted) |->
        ##[0:1] flags.zero) else $error("halt left zero flag clear");
    a_halt_idle: assert property (halted |=> !mem.req && !evoke_valid)
        else $error("activity while halted");
endmodule

bind pmf_sequencer pmf_sequencer_assertions pmf_sequencer_assertions_inst (
    .mclk(mclk), .rst_b(rst_b), .mem_ack(mem_ack), .mem_data(mem_data),
    .mem(mem), .evoke_valid(evoke_valid), .evoke_code(evoke_code),
    .xfer_done(xfer_done), .bus_data(bus_data), .flags(flags),
    .page_sel(page_sel), .mux_sel(mux_sel), .halted(halted)
);

// ### test/pmf_sequencer_tb.sv
`timescale 1ns/1ps
`define CHECK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
    fail_count++; $display("mismatch %s expected %h seen %h", nm, exp, got); \
    end end
module pmf_sequencer_tb
    import pmf_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic mem_ack, evoke_valid, xfer_done, page_sel, mux_sel, halted;
    logic [7:0] mem_data, evoke_code;
    pmf_mem_req_t mem;
    pmf_flags_t flags;
    logic [PMF_WORD_W-1:0] bus_data;
    logic [PMF_WORD_W-1:0] accum_data = 16'h0005;
    logic [PMF_WORD_W-1:0] arg_data = 16'hFFFF;
    logic [PMF_CHANS-1:0] test_first = 30'h00000002;
    logic [PMF_CHANS-1:0] test_second = 30'h00000000;
    logic [3:0] delay = 4'h0;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] seen [$];
    logic [15:0] expt [17];
    logic lean_mem_ack, lean_evoke_valid, lean_xfer_done;
    logic lean_page_sel, lean_mux_sel, lean_halted;
    logic [7:0] lean_mem_data;
    pmf_mem_req_t lean_mem;
    logic [PMF_WORD_W-1:0] lean_bus_data;

    always #10 mclk = ~mclk;

    pmf_sequencer pmf_sequencer_inst (.mclk(mclk), .rst_b(rst_b),
        .mem_ack(mem_ack), .mem_data(mem_data), .mem(mem),
        .evoke_valid(evoke_valid), .evoke_code(evoke_code),
        .xfer_done(xfer_done), .bus_data(bus_data),
        .accum_data(accum_data), .arg_data(arg_data),
        .test_first(test_first), .test_second(test_second), .flags(flags),
        .page_sel(page_sel), .mux_sel(mux_sel), .halted(halted));

    pmf_far_side pmf_far_side_inst (.mclk(mclk), .rst_b(rst_b),
        .delay(delay), .word(16'h8000), .mem(mem),
        .evoke_valid(evoke_valid), .mem_ack(mem_ack), .mem_data(mem_data),
        .xfer_done(xfer_done), .bus_data(bus_data));

    // build without paging or second multiplexer, same program
    pmf_sequencer #(.HAS_MUX_SECOND(1'b0), .WORDS_FITTED(PMF_PAGE_WORDS))
        pmf_sequencer_lean_inst (.mclk(mclk), .rst_b(rst_b),
        .mem_ack(lean_mem_ack), .mem_data(lean_mem_data), .mem(lean_mem),
        .evoke_valid(lean_evoke_valid), .evoke_code(),
        .xfer_done(lean_xfer_done), .bus_data(lean_bus_data),
        .accum_data(accum_data), .arg_data(arg_data),
        .test_first(test_first), .test_second(test_second), .flags(),
        .page_sel(lean_page_sel), .mux_sel(lean_mux_sel),
        .halted(lean_halted));

    pmf_far_side pmf_far_side_lean_inst (.mclk(mclk), .rst_b(rst_b),
        .delay(delay), .word(16'h8000), .mem(lean_mem),
        .evoke_valid(lean_evoke_valid), .mem_ack(lean_mem_ack),
        .mem_data(lean_mem_data), .xfer_done(lean_xfer_done),
        .bus_data(lean_bus_data));

    function automatic logic [15:0] e(logic [9:0] a, logic [2:0] f,
        logic p, logic m);
        return {a, f, p, m, 1'b0};
    endfunction

    // record address and visible state at every accepted fetch
    always @(posedge mclk) begin
        if (mem.req && mem_ack) begin
            seen.push_back(e(mem.addr, flags, page_sel, mux_sel));
        end
        if (evoke_valid && xfer_done) begin
            `CHECK("evoke code", 8'h2A, evoke_code)
        end
    end

    // hang guard: the two runs need well under a thousand cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // program: transfer, reexamines, mux swaps, jumps, page, call, halt
    // one word into both control stores
    task automatic put(input logic [9:0] a, input logic [7:0] op);
        pmf_far_side_inst.rom[a] = op;
        pmf_far_side_lean_inst.rom[a] = op;
    endtask

    task automatic load_program();
        for (int i = 0; i < PMF_WORDS_FITTED; i++) begin
            put(i[9:0], PMF_OP_HALT);
        end
        put(10'h000, 8'h2A);
        put(10'h001, PMF_OP_REEXAM_ACCUM);
        put(10'h002, PMF_OP_REEXAM_ARG);
        put(10'h003, PMF_OP_MUX_SECOND);
        put(10'h004, PMF_OP_JUMP_FIRST);
        put(10'h005, 8'h10);
        put(10'h010, 8'hC2);
        // lean build takes this jump and lands on a page command
        put(10'h011, 8'hFE);
        put(10'h012, PMF_OP_MUX_FIRST);
        put(10'h013, 8'hC3);
        put(10'h014, 8'hFE);
        put(10'h0FE, PMF_OP_PAGE_HIGH);
        put(10'h1FE, PMF_OP_REEXAM_ACCUM);
        put(10'h1FF, PMF_OP_PAGE_HIGH);
        put(10'h200, PMF_OP_CALL_LOW);
        put(10'h201, 8'h30);
        put(10'h230, PMF_OP_REEXAM_ACCUM);
        put(10'h231, PMF_OP_RETURN);
        put(10'h202, PMF_OP_HALT);
    endtask

    // reset, run to halt with the given answer wait, compare the trace
    task automatic run_program(input logic [3:0] wait_cycles);
        @(posedge mclk);
        rst_b <= 1'b0;
        delay <= wait_cycles;
        repeat (16) @(posedge mclk);
        seen.delete();
        rst_b <= 1'b1;
        for (int i = 0; i < 600 && halted !== 1'b1; i++) @(posedge mclk);
        @(posedge mclk);
        `CHECK("fetch count", 17, seen.size())
        for (int i = 0; i < 17 && i < seen.size(); i++) begin
            `CHECK("fetch trace", expt[i], seen[i])
        end
        `CHECK("halted", 1'b1, halted)
        `CHECK("halt flags", 3'h1, flags)
        `CHECK("page at end", 1'b1, page_sel)
        `CHECK("lean halted", 1'b1, lean_halted)
        `CHECK("lean mux", 1'b0, lean_mux_sel)
        `CHECK("lean page", 1'b0, lean_page_sel)
        `CHECK("lean last fetch", 10'h0FF, lean_mem.addr)
        $display("test run with wait %0d done", wait_cycles);
    endtask

    initial begin
        expt = '{e(10'h000, 3'h0, 1'b0, 1'b0), e(10'h001, 3'h2, 1'b0, 1'b0),
            e(10'h002, 3'h4, 1'b0, 1'b0), e(10'h003, 3'h2, 1'b0, 1'b0),
            e(10'h004, 3'h1, 1'b0, 1'b1), e(10'h005, 3'h1, 1'b0, 1'b1),
            e(10'h010, 3'h1, 1'b0, 1'b1), e(10'h012, 3'h1, 1'b0, 1'b1),
            e(10'h013, 3'h1, 1'b0, 1'b0), e(10'h014, 3'h1, 1'b0, 1'b0),
            e(10'h1FE, 3'h1, 1'b0, 1'b0), e(10'h1FF, 3'h4, 1'b0, 1'b0),
            e(10'h200, 3'h1, 1'b1, 1'b0), e(10'h201, 3'h1, 1'b1, 1'b0),
            e(10'h230, 3'h1, 1'b1, 1'b0), e(10'h231, 3'h4, 1'b1, 1'b0),
            e(10'h202, 3'h4, 1'b1, 1'b0)};
        load_program();
        run_program(4'h0);
        run_program(4'h3);
        print_verdict();
    end
endmodule
